//--- igp_leg.sv
// One phase leg: dead time, least on and off pulse widths, fault blocking
`timescale 1ns/1ps
`include "igp_consts.svh"
module igp_leg #(
    parameter int DEAD_CYC    = `IGP_DEAD_CYC,
    parameter int MIN_ON_CYC  = `IGP_MIN_ON_CYC,
    parameter int MIN_OFF_CYC = `IGP_MIN_OFF_CYC,
    parameter int MIN_OFF_HI  = `IGP_MIN_OFF_HI_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_high_req,
    input  wire logic i_low_req,
    input  wire logic i_block,
    input  wire logic i_high_current,
    output logic      o_high,
    output logic      o_low
);
    localparam int CW = `IGP_CNT_W;

    initial begin
        if (DEAD_CYC < 1 || MIN_ON_CYC < 1 || MIN_OFF_CYC < 1 || MIN_OFF_HI < 1 ||
            DEAD_CYC >= (1 << CW) || MIN_ON_CYC >= (1 << CW) || MIN_OFF_HI >= (1 << CW) ||
            MIN_OFF_CYC >= (1 << CW)) begin
            $error("igp_leg: timing counts out of range");
        end
    end

    function automatic logic [CW-1:0] max_cyc(input int a, input int b);
        max_cyc = (a > b) ? CW'(a) : CW'(b);
    endfunction

    igp_pkg::igp_leg_state_t state_q;
    igp_pkg::igp_leg_state_t state_d;
    logic [CW-1:0]           cnt_q;
    logic [CW-1:0]           cnt_d;
    logic [CW-1:0]           wait_cyc;
    logic                    high_q;
    logic                    high_d;
    logic                    low_q;
    logic                    low_d;
    logic                    gap_ok;

    always_comb begin
        // A load that turns heavy after a normal gap waits out the longer off width
        gap_ok   = !i_high_current ||
                   (int'(cnt_q) + int'(max_cyc(DEAD_CYC, MIN_OFF_CYC)) >= MIN_OFF_HI);
        // Off gap covers dead time and least off pulse for the present load
        wait_cyc = i_high_current ? max_cyc(DEAD_CYC, MIN_OFF_HI) : max_cyc(DEAD_CYC, MIN_OFF_CYC);
        state_d  = state_q;
        case (state_q)
            igp_pkg::S_IDLE: begin
                // Restart only from all-low with the fault released
                if (!i_block && gap_ok && i_high_req && !i_low_req) begin
                    state_d = igp_pkg::S_HIGH;
                end else if (!i_block && gap_ok && i_low_req && !i_high_req) begin
                    state_d = igp_pkg::S_LOW;
                end
            end
            igp_pkg::S_HIGH, igp_pkg::S_LOW: begin
                if (i_block) begin
                    state_d = igp_pkg::S_DEAD;
                end else if (cnt_q >= CW'(MIN_ON_CYC - 1)) begin
                    if ((state_q == igp_pkg::S_HIGH && !i_high_req) ||
                        (state_q == igp_pkg::S_LOW && !i_low_req)) begin
                        state_d = igp_pkg::S_DEAD;
                    end
                end
            end
            igp_pkg::S_DEAD: begin
                if (cnt_q >= wait_cyc - CW'(1)) begin
                    state_d = igp_pkg::S_IDLE;
                end
            end
            default: begin
                state_d = igp_pkg::S_IDLE;
            end
        endcase
        if (state_d != state_q) begin
            cnt_d = '0;
        end else if (cnt_q != {CW{1'b1}}) begin
            cnt_d = cnt_q + CW'(1);
        end else begin
            cnt_d = cnt_q;
        end
        high_d = (state_d == igp_pkg::S_HIGH);
        low_d  = (state_d == igp_pkg::S_LOW);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // Start with a full off gap: a gate may have been on just before reset
            state_q <= igp_pkg::S_DEAD;
            cnt_q   <= '0;
            high_q  <= 1'b0;
            low_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            high_q  <= high_d;
            low_q   <= low_d;
        end
    end

    assign o_high = high_q;
    assign o_low  = low_q;

    // Checker helpers: run lengths of the off gap and of the on pulse
    logic [CW-1:0] off_run_q;
    logic [CW-1:0] on_run_q;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            off_run_q <= '0;
            on_run_q  <= '0;
        end else begin
            off_run_q <= (high_q || low_q) ? '0 : ((off_run_q == {CW{1'b1}}) ? off_run_q : off_run_q + CW'(1));
            on_run_q  <= (high_q || low_q) ? ((on_run_q == {CW{1'b1}}) ? on_run_q : on_run_q + CW'(1)) : '0;
        end
    end

    sequence seq_switch_on;
        $rose(high_q || low_q);
    endsequence

    sequence seq_normal_off;
        $fell(high_q || low_q) && !$past(i_block);
    endsequence

    AST_NEVER_BOTH: assert property (@(posedge i_clk) disable iff (i_srst) !(high_q && low_q))
        else $error("both switches of a leg commanded on");
    AST_DEAD_GAP: assert property (@(posedge i_clk) disable iff (i_srst)
        seq_switch_on |-> off_run_q >= CW'(DEAD_CYC))
        else $error("switch on before the dead time elapsed");
    AST_MIN_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
        (seq_switch_on and (!i_high_current && $stable(i_high_current))) |-> off_run_q >= CW'(MIN_OFF_CYC))
        else $error("off pulse shorter than the least off width");
    AST_MIN_OFF_HI: assert property (@(posedge i_clk) disable iff (i_srst)
        (seq_switch_on and $past(i_high_current)) |-> off_run_q >= CW'(MIN_OFF_HI))
        else $error("off pulse shorter than the high current off width");
    AST_MIN_ON: assert property (@(posedge i_clk) disable iff (i_srst)
        seq_normal_off |-> $past(on_run_q) >= CW'(MIN_ON_CYC - 1))
        else $error("on pulse shorter than the least on width");
    AST_BLOCK_CUTS: assert property (@(posedge i_clk) disable iff (i_srst)
        i_block |=> !high_q && !low_q)
        else $error("gate still on one cycle after block");
endmodule

//--- igp_consts.svh
// Timing constants for the inverter gate controller
`ifndef IGP_CONSTS_SVH
`define IGP_CONSTS_SVH

`define IGP_CLK_MHZ         100
`define IGP_DEAD_NS         2000
`define IGP_MIN_ON_NS       1500
`define IGP_MIN_OFF_NS      1500
`define IGP_MIN_OFF_HI_NS   3000

// Least times round up to whole cycles
`define IGP_NS2CYC(ns)      ((((ns) * `IGP_CLK_MHZ) + 999) / 1000)
`define IGP_DEAD_CYC        `IGP_NS2CYC(`IGP_DEAD_NS)
`define IGP_MIN_ON_CYC      `IGP_NS2CYC(`IGP_MIN_ON_NS)
`define IGP_MIN_OFF_CYC     `IGP_NS2CYC(`IGP_MIN_OFF_NS)
`define IGP_MIN_OFF_HI_CYC  `IGP_NS2CYC(`IGP_MIN_OFF_HI_NS)

`define IGP_CNT_W           9

`endif

//--- igp_pkg.sv
// Types for the inverter gate controller
package igp_pkg;
    typedef enum logic [1:0] {
        S_IDLE,
        S_HIGH,
        S_LOW,
        S_DEAD
    } igp_leg_state_t;
endpackage

//--- igp_ctrl.sv
// Three-phase gate command controller facing the inverter power module
`timescale 1ns/1ps
`include "igp_consts.svh"
// How it works
// - Fault line is open drain, low when asserted; controller only senses it, the pull-up is outside.
// - Controller leaves at least 2.0 us between one switch off and opposite on.
// - Controller keeps each on pulse at least 1.5 us long, except one that a block cuts short.
// - Controller keeps off pulses at least 1.5 us, or 3.0 us at high current.
module igp_ctrl #(
    parameter int PHASES      = 3,
    parameter int DEAD_CYC    = `IGP_DEAD_CYC,
    parameter int MIN_ON_CYC  = `IGP_MIN_ON_CYC,
    parameter int MIN_OFF_CYC = `IGP_MIN_OFF_CYC,
    parameter int MIN_OFF_HI  = `IGP_MIN_OFF_HI_CYC
) (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    input  wire logic              i_enable,
    input  wire logic              i_high_current,
    input  wire logic [PHASES-1:0] i_high_req,
    input  wire logic [PHASES-1:0] i_low_req,
    input  wire logic              i_fault_line_n,
    output logic      [PHASES-1:0] o_high_gate,
    output logic      [PHASES-1:0] o_low_gate,
    output logic                   o_fault_active,
    output logic                   o_fault_seen
);
    initial begin
        if (PHASES != 3) begin
            $error("igp_ctrl: the power module has exactly three phase legs");
        end
    end

    logic fault_now;
    logic fault_q;
    logic fault_d;
    logic seen_q;
    logic seen_d;
    logic block;

    // Open-drain line: a low level means the module reports a fault
    assign fault_now = !i_fault_line_n;

    always_comb begin
        fault_d = fault_now;
        // Event latch: a new fault wins over the clear by a disabled controller
        if (fault_now) begin
            seen_d = 1'b1;
        end else if (!i_enable) begin
            seen_d = 1'b0;
        end else begin
            seen_d = seen_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fault_q <= 1'b0;
            seen_q  <= 1'b0;
        end else begin
            fault_q <= fault_d;
            seen_q  <= seen_d;
        end
    end

    // Pulses stop while the line is low and until software re-enables
    assign block = fault_now || seen_q || !i_enable;

    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_leg
            igp_leg #(
                .DEAD_CYC    (DEAD_CYC),
                .MIN_ON_CYC  (MIN_ON_CYC),
                .MIN_OFF_CYC (MIN_OFF_CYC),
                .MIN_OFF_HI  (MIN_OFF_HI)
            ) u_leg (
                .i_clk          (i_clk),
                .i_srst         (i_srst),
                .i_high_req     (i_high_req[g]),
                .i_low_req      (i_low_req[g]),
                .i_block        (block),
                .i_high_current (i_high_current),
                .o_high         (o_high_gate[g]),
                .o_low          (o_low_gate[g])
            );
        end
    endgenerate

    assign o_fault_active = fault_q;
    assign o_fault_seen   = seen_q;

    sequence seq_fault_edge;
        $fell(i_fault_line_n);
    endsequence

    sequence seq_all_low_2;
        (o_high_gate == '0 && o_low_gate == '0) [*2];
    endsequence

    AST_FAULT_STOPS: assert property (@(posedge i_clk) disable iff (i_srst)
        seq_fault_edge |=> seq_all_low_2)
        else $error("gates not stopped after fault");
    AST_FAULT_SENSE: assert property (@(posedge i_clk) disable iff (i_srst)
        o_fault_active == !$past(i_fault_line_n))
        else $error("fault level not followed");
    AST_LATCHED_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        o_fault_seen && i_enable |=> o_fault_seen)
        else $error("fault latch dropped while enabled");
    AST_NO_GATE_WHILE_LATCHED: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(o_fault_seen) && o_fault_seen |-> o_high_gate == '0 && o_low_gate == '0)
        else $error("gate on while fault latched");
endmodule

//--- igp_dev_model.sv
// Behavioural model of the power module that the gate controller drives
`timescale 1ns/1ps
module igp_dev_model #(
    parameter int FAULT_CYC = 40
) (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_high_gate,
    input  wire logic [2:0] i_low_gate,
    input  wire logic       i_sc_trip,
    input  wire logic       i_uv_trip,
    input  wire logic [2:0] i_hs_uv,
    output logic            o_fault_pull,
    output logic      [2:0] o_high_sw,
    output logic      [2:0] o_low_sw
);
    int         cnt_q  = 0;
    logic       uv_q   = 1'b0;
    logic [2:0] blk_q  = 3'h7;
    logic [2:0] prev_q = 3'h0;
    logic [2:0] hblk_q  = 3'h7;
    logic [2:0] hprev_q = 3'h0;
    logic       trip;
    assign trip = i_sc_trip | i_uv_trip;
    always @(posedge i_clk) begin
        prev_q <= i_low_gate;
        hprev_q <= i_high_gate;
        // High side blocks on its own supply dip and frees on a fresh rising input once recovered
        hblk_q  <= (hblk_q | i_hs_uv) & ~(i_high_gate & ~hprev_q & ~i_hs_uv);
        uv_q   <= i_uv_trip;
        if (i_sc_trip || (i_uv_trip && !uv_q)) begin
            cnt_q <= FAULT_CYC;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
        if (trip || o_fault_pull) begin
            blk_q <= 3'h7;
        end else begin
            blk_q <= blk_q & ~(i_low_gate & ~prev_q);
        end
    end
    assign o_fault_pull = (cnt_q > 0) || i_uv_trip;
    // Short off pulses are answered at once, which the module is allowed to do
    assign o_high_sw    = i_high_gate & ~hblk_q & ~i_hs_uv;
    assign o_low_sw     = i_low_gate & ~blk_q & ~{3{trip}};
endmodule

//--- testbench.sv
// Self-checking bench for the gate controller against the module model
`timescale 1ns/1ps
module testbench;
    localparam int DEAD = 4;
    localparam int MON  = 5;
    localparam int MHI  = 6;
    localparam int FLT  = 40;
    logic       clk  = 1'b0;
    logic       srst = 1'b1;
    logic       en   = 1'b0;
    logic       hc   = 1'b0;
    logic [2:0] hreq = 3'h0;
    logic [2:0] lreq = 3'h0;
    logic       sc   = 1'b0;
    logic       uv   = 1'b0;
    logic [2:0] hsuv = 3'h0;
    logic       pull;
    logic       line_n;
    logic [2:0] hg;
    logic [2:0] lg;
    logic [2:0] hsw;
    logic [2:0] lsw;
    logic       fa;
    logic       fs;
    int         fail_count = 0;
    int         checked    = 0;

    always #5 clk = ~clk;
    // Pull-up on the open-drain fault line
    assign line_n = pull ? 1'b0 : 1'b1;

    igp_ctrl #(.DEAD_CYC(DEAD), .MIN_ON_CYC(MON), .MIN_OFF_CYC(3), .MIN_OFF_HI(MHI)) DUT (
        .i_clk(clk), .i_srst(srst), .i_enable(en), .i_high_current(hc), .i_high_req(hreq),
        .i_low_req(lreq), .i_fault_line_n(line_n), .o_high_gate(hg), .o_low_gate(lg),
        .o_fault_active(fa), .o_fault_seen(fs));
    igp_dev_model #(.FAULT_CYC(FLT)) dev (
        .i_clk(clk), .i_high_gate(hg), .i_low_gate(lg), .i_sc_trip(sc), .i_uv_trip(uv), .i_hs_uv(hsuv),
        .o_fault_pull(pull), .o_high_sw(hsw), .o_low_sw(lsw));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic chk_min(input string nm, input int lo, input int got);
        checked++;
        if (got < lo) begin
            fail_count++;
            $display("mismatch %s expected at least %0d seen %0d", nm, lo, got);
        end
    endtask
    task automatic idle();
        hreq = 3'h0;
        lreq = 3'h0;
        cyc(MHI + 6);
    endtask
    task automatic low_time(output int n);
        n = 0;
        while (line_n === 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
    endtask
    // Hands a leg from its high switch to its low switch, counting the gap
    task automatic swap(input int p, output int n);
        n = 0;
        hreq[p] = 1'b0;
        lreq[p] = 1'b1;
        while (lg[p] !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
            chk("shoot", 8'h00, {7'h0, hg[p] & lg[p]});
        end
        cyc(1);
        chk("low_sw", {5'h0, lg}, {5'h0, lsw});
    endtask

    task automatic t_phases();
        int n;
        for (int p = 0; p < 3; p++) begin
            hreq[p] = 1'b1;
            cyc(MON + 2);
            chk("high_gate", {5'h0, 3'h1 << p}, {5'h0, hg});
            swap(p, n);
            chk_min("dead_gap", DEAD + 1, n);
            idle();
        end
        $display("phases test done");
    endtask
    task automatic t_min();
        int n = 0;
        lreq[0] = 1'b1;
        cyc(1);
        lreq[0] = 1'b0;
        cyc(1);
        while (lg[0] === 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        chk_min("on_width", MON - 1, n);
        idle();
        $display("short pulse test done");
    endtask
    task automatic t_hc_both();
        int n;
        hc = 1'b1;
        hreq[2] = 1'b1;
        cyc(MON + 2);
        swap(2, n);
        chk_min("hc_gap", MHI + 1, n);
        hc = 1'b0;
        idle();
        hreq = 3'h2;
        lreq = 3'h2;
        cyc(8);
        chk("both", 8'h00, {2'h0, hg, lg});
        idle();
        $display("gap test done");
    endtask
    task automatic t_fault();
        int n;
        hreq[0] = 1'b1;
        lreq[2] = 1'b1;
        cyc(4);
        chk("gates_on", 8'h0c, {2'h0, hg, lg});
        sc = 1'b1;
        #1;
        chk("trip_sw", 8'h08, {2'h0, hsw, lsw});
        cyc(1);
        sc = 1'b0;
        cyc(1);
        chk("fault_on", 8'h03, {hg, lg, fa, fs});
        low_time(n);
        chk_min("fault_width", FLT - 3, n);
        cyc(2);
        chk("fault_held", 8'h01, {hg, lg, fa, fs});
        en = 1'b0;
        cyc(2);
        chk("seen_clr", 8'h00, {6'h0, fa, fs});
        en = 1'b1;
        idle();
        lreq[2] = 1'b1;
        cyc(4);
        chk("restart", 8'h04, {5'h0, lsw});
        idle();
        $display("short circuit test done");
    endtask
    task automatic t_hs_uv();
        hreq[1] = 1'b1;
        cyc(3);
        chk("hs_on", 8'h02, {5'h0, hsw});
        hsuv[1] = 1'b1;
        cyc(2);
        chk("hs_uv_off", 8'h00, {5'h0, hsw});
        chk("hs_uv_nofault", 8'h02, {6'h0, line_n, fa});
        hsuv[1] = 1'b0;
        cyc(2);
        chk("hs_held", 8'h00, {5'h0, hsw});
        idle();
        hreq[1] = 1'b1;
        cyc(3);
        chk("hs_fresh", 8'h02, {5'h0, hsw});
        idle();
        $display("high side supply test done");
    endtask
    task automatic t_uv();
        int n;
        uv = 1'b1;
        cyc(FLT + 20);
        chk("uv_held", 8'h01, {6'h0, line_n, fa});
        uv = 1'b0;
        cyc(2);
        chk("uv_end", 8'h02, {6'h0, line_n, fa});
        uv = 1'b1;
        cyc(1);
        uv = 1'b0;
        low_time(n);
        chk_min("uv_min", FLT - 2, n);
        en = 1'b0;
        cyc(2);
        en = 1'b1;
        $display("under-voltage test done");
    endtask

    task automatic stop_test();
        $display("counts: checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(3);
        srst = 1'b0;
        cyc(1);
        chk("reset_out", 8'h00, {hg, lg, fa, fs});
        en = 1'b1;
        t_phases();
        t_min();
        t_hc_both();
        t_fault();
        t_hs_uv();
        t_uv();
        stop_test();
    end
    initial begin
        #100000;
        fail_count++;
        $display("mismatch watchdog expected done seen timeout");
        stop_test();
    end
endmodule
